/* common/stieirq_pkg.sv */
/*
 Constants for the switch input edge interrupt block: register offsets,
 field layout, reset values and crossing codes.
 Assumes a 32-bit AXI4-Lite register bus.
*/
`default_nettype none
package stieirq_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] TWO_EN_IDX = 8'h26;
    localparam logic [7:0] THREE_EN_IDX = 8'h27;
    localparam logic [7:0] STATUS_IDX = 8'h28;
    localparam logic [7:0] MASK_IDX = 8'h29;
    localparam logic [7:0] LEVEL_IDX = 8'h2a;
    localparam int ADDR_W = 10;
    localparam int ENABLE_W = 24;
    localparam logic [23:0] ENABLE_RST = 24'h000000;
    localparam logic [23:0] MASK_RST = 24'h000000;
    // Two-threshold group: inputs 12..17, 4-bit fields from bit 0
    localparam int TWO_INPUTS = 6;
    localparam int TWO_FIELD_W = 4;
    // Three-threshold group: inputs 18..21, 6-bit fields from bit 0
    localparam int THREE_INPUTS = 4;
    localparam int THREE_FIELD_W = 6;
    // 6*2 + 4*3 comparator outputs
    localparam int CMP_N = 24;
    localparam int THREE_BASE = 12;
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_UP = 2'h1;
    localparam logic [1:0] EDGE_DOWN = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* src/stieirq_edge_det.sv */
/*
 One comparator output: edge detection gated by a 2-bit crossing select.
 Assumes the comparator level is synchronous to clk.
*/
`default_nettype none
module stieirq_edge_det import stieirq_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rstB,
    // Comparator and select
    input wire logic level,
    input wire logic [1:0] edgeSel,
    // Event
    output logic hit
);
    logic prev_q;

    always_ff @(posedge clk or negedge rstB) begin
        if (!rstB) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= level;
        end
    end

    always_comb begin
        case (edgeSel)
            EDGE_UP: hit = level & ~prev_q;
            EDGE_DOWN: hit = ~level & prev_q;
            EDGE_BOTH: hit = level ^ prev_q;
            default: hit = 1'b0;
        endcase
    end

    a_none_no_hit: assert property (@(posedge clk) disable iff (!rstB)
        edgeSel == EDGE_NONE |-> !hit)
        else $error("hit raised with crossing select off");
endmodule
`default_nettype wire

/* src/stieirq_regs.sv */
/*
 AXI4-Lite slave holding the two enable registers, sticky status and mask.
 Assumes one outstanding write and one outstanding read from the master.
*/
// The AXI4-Lite slave port was left to the implementer.
`default_nettype none
module stieirq_regs import stieirq_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rstB,
    // AXI4-Lite
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Block side
    input wire logic [CMP_N-1:0] events,
    input wire logic [CMP_N-1:0] levels,
    output logic [ENABLE_W-1:0] twoEn,
    output logic [ENABLE_W-1:0] threeEn,
    output logic [CMP_N-1:0] status,
    output logic [CMP_N-1:0] mask
);
    logic [ADDR_W-1:0] awAddr_q;
    logic awHeld_q, wHeld_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic doWrite;
    logic [7:0] wIdx, rIdx;
    logic [31:0] wMask;
    logic [CMP_N-1:0] clrBits;

    assign awready = !awHeld_q && !bvalid;
    assign wready = !wHeld_q && !bvalid;
    assign arready = !rvalid;
    assign doWrite = awHeld_q && wHeld_q && !bvalid;
    assign wIdx = awAddr_q[ADDR_W-1:2];
    assign rIdx = araddr[ADDR_W-1:2];
    assign wMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}},
                    {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};

    // Address and data may arrive in either order
    always_ff @(posedge clk or negedge rstB) begin
        if (!rstB) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= '0;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= awaddr;
            end else if (doWrite) begin
                awHeld_q <= 1'b0;
            end
            if (wvalid && wready) begin
                wHeld_q <= 1'b1;
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end else if (doWrite) begin
                wHeld_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstB) begin
        if (!rstB) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= (wIdx == TWO_EN_IDX || wIdx == THREE_EN_IDX ||
                      wIdx == STATUS_IDX || wIdx == MASK_IDX)
                     ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstB) begin
        if (!rstB) begin
            twoEn <= ENABLE_RST;
            threeEn <= ENABLE_RST;
            mask <= MASK_RST;
        end else if (doWrite) begin
            if (wIdx == TWO_EN_IDX)
                twoEn <= (twoEn & ~wMask[23:0]) | (wData_q[23:0] & wMask[23:0]);
            if (wIdx == THREE_EN_IDX)
                threeEn <= (threeEn & ~wMask[23:0])
                           | (wData_q[23:0] & wMask[23:0]);
            if (wIdx == MASK_IDX)
                mask <= (mask & ~wMask[23:0]) | (wData_q[23:0] & wMask[23:0]);
        end
    end

    assign clrBits = (doWrite && wIdx == STATUS_IDX)
                     ? (wData_q[23:0] & wMask[23:0]) : '0;

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk or negedge rstB) begin
        if (!rstB) begin
            status <= '0;
        end else begin
            status <= (status & ~clrBits) | events;
        end
    end

    always_ff @(posedge clk or negedge rstB) begin
        if (!rstB) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= RESP_OKAY;
            case (rIdx)
                TWO_EN_IDX: rdata <= {8'h00, twoEn};
                THREE_EN_IDX: rdata <= {8'h00, threeEn};
                STATUS_IDX: rdata <= {8'h00, status};
                MASK_IDX: rdata <= {8'h00, mask};
                LEVEL_IDX: rdata <= {8'h00, levels};
                default: begin
                    rdata <= 32'h00000000;
                    rresp <= RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    a_set_beats_clear: assert property (@(posedge clk) disable iff (!rstB)
        events != '0 |=> (status & $past(events)) == $past(events))
        else $error("status event lost");
    a_write_two_en: assert property (@(posedge clk) disable iff (!rstB)
        doWrite && wIdx == TWO_EN_IDX && wStrb_q == 4'hf
        |=> twoEn == $past(wData_q[23:0]))
        else $error("two-threshold enable not written");
    a_write_three_en: assert property (@(posedge clk) disable iff (!rstB)
        doWrite && wIdx == THREE_EN_IDX && wStrb_q == 4'hf
        |=> threeEn == $past(wData_q[23:0]))
        else $error("three-threshold enable not written");
endmodule
`default_nettype wire

/* src/stieirq_top.sv */
/*
 Edge interrupt enables for switch inputs 12..21 with sticky status,
 mask and one level interrupt. Assumes comparator levels arrive
 synchronous to clk, ordered first threshold lowest per input.
*/
`default_nettype none
// How it works
// - Low pair of a 4-bit field: 01 up, 10 down, 11 both, 00 none.
// - High pair of a 4-bit field: same coding for the second threshold.
// - A zero pair blocks its threshold only, whatever the other pair says.
// - Inputs 12, 13, 14 use bits 3-0, 7-4, 11-8.
// - Inputs 15, 16, 17 use bits 15-12, 19-16, 23-20.
// - All enable fields read and write and reset to zero.
// - Register at 27h, reset zero, 6-bit fields inputs 18..21 upward.
// - Each 6-bit field holds three pairs, lowest pair first threshold.
// - Two-threshold register sits at 26h, reset zero.
module stieirq_top import stieirq_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // AXI4-Lite
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Comparators: 2 per input 12..17, then 3 per input 18..21
    input wire logic [CMP_N-1:0] cmpAbove,
    // Interrupt
    output logic irq
);
    logic rstSync1_q, rstB;
    logic [ENABLE_W-1:0] twoEn, threeEn;
    logic [CMP_N-1:0] sel0, sel1, hits, status, mask;
    logic [1:0] sels [CMP_N];
    logic irqAny;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync1_q <= 1'b0;
            rstB <= 1'b0;
        end else begin
            rstSync1_q <= 1'b1;
            rstB <= rstSync1_q;
        end
    end

    // Two-threshold fields map straight: pair k of the register is cmp k
    genvar g;
    generate
        for (g = 0; g < THREE_BASE; g++) begin : gTwo
            assign sels[g] = twoEn[2*g +: 2];
        end
        for (g = THREE_BASE; g < CMP_N; g++) begin : gThree
            assign sels[g] = threeEn[2*(g-THREE_BASE) +: 2];
        end
        for (g = 0; g < CMP_N; g++) begin : gDet
            stieirq_edge_det uDet (
                .clk(clk),
                .rstB(rstB),
                .level(cmpAbove[g]),
                .edgeSel(sels[g]),
                .hit(hits[g])
            );
            assign sel0[g] = sels[g][0];
            assign sel1[g] = sels[g][1];
        end
    endgenerate

    stieirq_regs uRegs (
        .clk(clk),
        .rstB(rstB),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .events(hits),
        .levels(cmpAbove),
        .twoEn(twoEn),
        .threeEn(threeEn),
        .status(status),
        .mask(mask)
    );

    // Registered so the pin never glitches on status decode
    assign irqAny = |(status & mask);
    always_ff @(posedge clk or negedge rstB) begin
        if (!rstB) begin
            irq <= 1'b0;
        end else begin
            irq <= irqAny;
        end
    end

    a_reset_quiet: assert property (@(posedge clk) disable iff (!rstB)
        (twoEn == '0 && threeEn == '0) |=> !$rose(|status))
        else $error("status set with all enables zero");
    a_rise_recorded: assert property (@(posedge clk) disable iff (!rstB)
        ($rose(cmpAbove[0]) && sel0[0] && !sel1[0]) |=> status[0])
        else $error("rising crossing not recorded");
    a_fall_recorded: assert property (@(posedge clk) disable iff (!rstB)
        ($fell(cmpAbove[1]) && sel1[1]) |=> status[1])
        else $error("falling crossing on second threshold lost");
    a_field_in17: assert property (@(posedge clk) disable iff (!rstB)
        sels[11] == twoEn[23:22] && sels[0] == twoEn[1:0])
        else $error("two-threshold field misplaced");
    a_field_in21: assert property (@(posedge clk) disable iff (!rstB)
        sels[23] == threeEn[23:22] && sels[12] == threeEn[1:0])
        else $error("three-threshold field misplaced");
    a_irq_follows: assert property (@(posedge clk) disable iff (!rstB)
        (|(status & mask)) |=> irq)
        else $error("interrupt not raised for masked-in status");
    a_pair_indep: assert property (@(posedge clk) disable iff (!rstB)
        (sels[2] == EDGE_NONE && $changed(cmpAbove[2]) && !status[2]
         && !$past(hits[2])) |=> !status[2])
        else $error("disabled threshold recorded a crossing");
endmodule
`default_nettype wire

/* sim/stieirq_cmp_model.sv */
/*
 Comparator bank model: threshold levels seen by the block.
 Assumes the bench sets wanted levels just after a clock edge.
*/
`default_nettype none
module stieirq_cmp_model (
    // Clock
    input wire logic clk,
    // Wanted levels and settling mode
    input wire logic [23:0] want,
    input wire logic slow,
    // Comparator outputs
    output logic [23:0] cmpAbove
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] stage_q;
    // Slow mode adds a settling cycle, as a filtered comparator would
    always_ff @(posedge clk) begin
        stage_q <= want;
        cmpAbove <= slow ? stage_q : want;
    end
endmodule
`default_nettype wire

/* sim/switch_input_edge_irq_enables_bench.sv */
/*
 Self-checking bench: register access, every crossing code on every
 comparator, masking. Assumes stieirq_cmp_model drives the comparators.
*/
`default_nettype none
module switch_input_edge_irq_enables_bench import stieirq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [9:0] A_TWO = {TWO_EN_IDX, 2'h0};
    localparam logic [9:0] A_THREE = {THREE_EN_IDX, 2'h0};
    localparam logic [9:0] A_STAT = {STATUS_IDX, 2'h0};
    localparam logic [9:0] A_MASK = {MASK_IDX, 2'h0};
    localparam logic [9:0] A_LVL = {LEVEL_IDX, 2'h0};
    logic clk, rstB, awvalid, wvalid, bready, arvalid, rready, slow;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [9:0] awaddr, araddr, adr;
    logic [31:0] wdata, rdata, v, ev;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r, c;
    logic [23:0] want, cmpAbove;
    logic [9:0] rstAddr[4] = '{A_TWO, A_THREE, A_STAT, A_MASK};
    int b, ci, d, pos;
    int miscompares = 0;
    int samples_checked = 0;

    stieirq_top dut (.clk(clk), .rst_b(rstB), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .cmpAbove(cmpAbove), .irq(irq));
    stieirq_cmp_model cmp (.clk(clk), .want(want), .slow(slow),
        .cmpAbove(cmpAbove));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("Compared %0d, mismatched %0d", samples_checked,
                 miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Ready is sampled before this edge's updates land
    task automatic axWrite(input logic [9:0] a, input logic [31:0] dat,
                           input logic [3:0] s, output logic [1:0] resp);
        awaddr <= a;
        wdata <= dat;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
    endtask

    task automatic axRead(input logic [9:0] a, output logic [31:0] dat,
                          output logic [1:0] resp);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        dat = rdata;
        resp = rresp;
    endtask

    initial begin
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        bready = 1'b1;
        rready = 1'b1;
        awaddr = 10'h0;
        araddr = 10'h0;
        wdata = 32'h0;
        wstrb = 4'h0;
        want = 24'h0;
        slow = 1'b0;
        rstB = 1'b0;
        repeat (6) @(posedge clk);
        rstB <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (rstAddr[i]) begin
            axRead(rstAddr[i], v, r);
            check("reset value", v, 32'h0);
        end
        check("irq after reset", {31'h0, irq}, 32'h0);
        axRead(10'h000, v, r);
        check("unmapped read data", v, 32'h0);
        check("unmapped read resp", {30'h0, r}, {30'h0, RESP_SLVERR});
        axWrite(10'h3fc, 32'hffffffff, 4'hf, r);
        check("unmapped write resp", {30'h0, r}, {30'h0, RESP_SLVERR});
        axWrite(A_TWO, 32'hffffffff, 4'hf, r);
        axRead(A_TWO, v, r);
        check("two enable full", v, 32'h00ffffff);
        axWrite(A_THREE, 32'h12345678, 4'h2, r);
        axRead(A_THREE, v, r);
        check("three enable strobe", v, 32'h00005600);
        axWrite(A_TWO, 32'h0, 4'hf, r);
        axWrite(A_THREE, 32'h0, 4'hf, r);
        // Crossings with all enables off must leave status clear
        want <= 24'h5a5a5a;
        repeat (6) @(posedge clk);
        axRead(A_LVL, v, r);
        check("levels", v, 32'h005a5a5a);
        want <= 24'h0;
        repeat (6) @(posedge clk);
        axRead(A_STAT, v, r);
        check("status while disabled", v, 32'h0);
        axWrite(A_MASK, 32'h00ffffff, 4'hf, r);
        // Other pairs set to both edges: only the pair under test counts
        for (b = 0; b < 24; b++) begin
            for (ci = 0; ci < 4; ci++) begin
                c = 2'(ci);
                pos = b < 12 ? 4 * (b / 2) + 2 * (b % 2)
                    : 6 * ((b - 12) / 3) + 2 * ((b - 12) % 3);
                adr = b < 12 ? A_TWO : A_THREE;
                ev = (32'h00ffffff & ~(32'h3 << pos)) | (32'(c) << pos);
                slow <= 1'(b % 2);
                axWrite(adr, ev, 4'hf, r);
                axRead(adr, v, r);
                check("enable readback", v, ev);
                axWrite(A_STAT, 32'h00ffffff, 4'hf, r);
                for (d = 0; d < 2; d++) begin
                    want[b] <= (d == 0);
                    repeat (6) @(posedge clk);
                    axRead(A_STAT, v, r);
                    check("status", v, c[d] ? 32'h1 << b : 32'h0);
                    check("irq", {31'h0, irq}, {31'h0, c[d]});
                    axWrite(A_STAT, 32'h00ffffff, 4'hf, r);
                end
            end
        end
        axWrite(A_MASK, 32'h0, 4'hf, r);
        want[0] <= 1'b1;
        repeat (6) @(posedge clk);
        axRead(A_STAT, v, r);
        check("masked status", v, 32'h1);
        check("masked irq", {31'h0, irq}, 32'h0);
        axWrite(A_MASK, 32'h1, 4'hf, r);
        repeat (2) @(posedge clk);
        check("unmasked irq", {31'h0, irq}, 32'h1);
        axWrite(A_STAT, 32'h1, 4'hf, r);
        repeat (2) @(posedge clk);
        check("cleared irq", {31'h0, irq}, 32'h0);
        wrap_up();
    end

    // Whole run needs about 3000 cycles
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
endmodule
`default_nettype wire
